// ==== core/vds_pkg.sv ====
/*
  vds_pkg: constants, register map and carrier types for the valve dispense sequencer.
  Assumes one 10 MHz clock and an APB master with 32-bit data.
*/
`default_nettype none
package vds_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // setting limits in microseconds
  localparam logic [23:0] PERIOD_MIN_US = 24'h0007d0;
  localparam logic [23:0] PERIOD_MAX_US = 24'h98967c;
  localparam logic [23:0] OPEN_MIN_US   = 24'h000064;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_COUNT  = 8'h04;
  localparam logic [7:0] OFS_PERIOD = 8'h08;
  localparam logic [7:0] OFS_OPEN   = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_POWER    = 2;
  localparam int CTRL_PURGE    = 3;
  // status field positions
  localparam int STAT_DISP   = 0;
  localparam int STAT_PURGE  = 1;
  localparam int STAT_CLOSE  = 2;
  localparam int STAT_ERR    = 3;
  localparam int STAT_REM_LSB = 16;
  // reset values
  localparam logic        POWER_RST  = 1'b1;
  localparam logic [15:0] COUNT_RST  = 16'h0001;
  localparam logic [23:0] PERIOD_RST = 24'h003a98;
  localparam logic [23:0] OPEN_RST   = 24'h000320;

  typedef enum logic [1:0] {
    VDS_TIMED = 2'h0,
    VDS_CONT  = 2'h1,
    VDS_EXT   = 2'h2
  } vds_mode_t;

  typedef enum logic [2:0] {
    VDS_IDLE = 3'h1,
    VDS_OPEN = 3'h2,
    VDS_GAP  = 3'h4
  } vds_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } vds_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } vds_apb_rsp_t;
endpackage
`default_nettype wire

// ==== core/vds_top.sv ====
/*
  vds_top: valve dispense sequencer with APB registers, timed, continuous and
  external modes, purge toggle and valve power gate.
  Assumes initiate, external drive and error lines are asynchronous pins and
  that the valve driver closes the valve while valve_close is high.
*/
// The implementer's own choices: the address map and the APB register port.
`default_nettype none
module vds_top
  import vds_pkg::*;
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // register bus
  input  wire vds_pkg::vds_apb_req_t apb_req,
  output vds_pkg::vds_apb_rsp_t      apb_rsp,
  // pins from initiate source and system
  input  wire logic                  initiate_pin,
  input  wire logic                  ext_drive_pin,
  input  wire logic                  error_pin,
  // valve driver
  output logic                       valve_close,
  output logic                       dispensing
);
  import vds_pkg::*;

  // synchronisers
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic       init_s;
  logic       ext_s;
  logic       err_s;
  logic       init_d;
  logic       init_rise;

  // configuration
  vds_mode_t   mode;
  logic        power_en;
  logic [15:0] count_cfg;
  logic [23:0] period_us;
  logic [23:0] open_us;
  logic        purge_req;
  logic        purging;

  // sequencer
  vds_state_t  state;
  vds_state_t  next_state;
  logic [3:0]  pre;
  logic [23:0] us_cnt;
  logic        tick;
  logic        open_end;
  logic        period_end;
  logic        start_ok;
  logic        restart;
  logic        last_dep;
  logic [15:0] remaining;
  logic        valve_open;

  // bus decode
  logic        setup;
  logic        wr_acc;
  logic        mapped;
  logic [31:0] next_rdata;
  logic [31:0] rdata_q;
  logic        slverr_q;

  assign init_s = sync2[0];
  assign ext_s  = sync2[1];
  assign err_s  = sync2[2];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {error_pin, ext_drive_pin, initiate_pin};
      sync2 <= sync1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      init_d <= 1'b0;
    end else begin
      init_d <= init_s;
    end
  end

  assign init_rise = init_s & ~init_d;

  // apb slave, zero wait states
  assign setup  = apb_req.psel & ~apb_req.penable;
  assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign mapped = (apb_req.paddr == OFS_CTRL) | (apb_req.paddr == OFS_COUNT) |
                  (apb_req.paddr == OFS_PERIOD) | (apb_req.paddr == OFS_OPEN) |
                  (apb_req.paddr == OFS_STATUS);

  always_comb begin
    next_rdata = 32'h0;
    case (apb_req.paddr)
      OFS_CTRL: begin
        next_rdata[CTRL_MODE_LSB +: 2] = mode;
        next_rdata[CTRL_POWER]         = power_en;
      end
      OFS_COUNT:  next_rdata[15:0] = count_cfg;
      OFS_PERIOD: next_rdata[23:0] = period_us;
      OFS_OPEN:   next_rdata[23:0] = open_us;
      OFS_STATUS: begin
        next_rdata[STAT_DISP]             = dispensing;
        next_rdata[STAT_PURGE]            = purging;
        next_rdata[STAT_CLOSE]            = valve_close;
        next_rdata[STAT_ERR]              = err_s;
        next_rdata[STAT_REM_LSB +: 16]    = remaining;
      end
      default: next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q  <= 32'h0;
      slverr_q <= 1'b0;
    end else if (setup) begin
      rdata_q  <= apb_req.pwrite ? 32'h0 : next_rdata;
      slverr_q <= ~mapped;
    end
  end

  // response carrier, one driver; pready tied high
  assign apb_rsp = '{pready: 1'b1, pslverr: slverr_q, prdata: rdata_q};

  // control register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode     <= VDS_TIMED;
      power_en <= POWER_RST;
    end else if (wr_acc && apb_req.paddr == OFS_CTRL) begin
      if (apb_req.pwdata[CTRL_MODE_LSB +: 2] != 2'h3) begin
        mode <= vds_mode_t'(apb_req.pwdata[CTRL_MODE_LSB +: 2]);
      end
      power_en <= apb_req.pwdata[CTRL_POWER];
    end
  end

  assign purge_req = wr_acc & (apb_req.paddr == OFS_CTRL) & apb_req.pwdata[CTRL_PURGE];

  // timing registers; out-of-range writes are ignored
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_cfg <= COUNT_RST;
      period_us <= PERIOD_RST;
      open_us   <= OPEN_RST;
    end else if (wr_acc) begin
      if (apb_req.paddr == OFS_COUNT && apb_req.pwdata[15:0] != 16'h0) begin
        count_cfg <= apb_req.pwdata[15:0];
      end
      if (apb_req.paddr == OFS_PERIOD && apb_req.pwdata[23:0] >= PERIOD_MIN_US &&
          apb_req.pwdata[23:0] <= PERIOD_MAX_US) begin
        period_us <= apb_req.pwdata[23:0];
      end
      if (apb_req.paddr == OFS_OPEN && apb_req.pwdata[23:0] >= OPEN_MIN_US) begin
        open_us <= apb_req.pwdata[23:0];
      end
    end
  end

  // purge toggle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      purging <= 1'b0;
    end else if (purging) begin
      if (purge_req || !power_en) begin
        purging <= 1'b0;
      end
    end else if (purge_req && power_en && !dispensing && !start_ok && !err_s) begin
      purging <= 1'b1;
    end
  end

  // microsecond time base, restarted at each deposit start
  assign tick       = (pre == 4'(TICK_CYCLES - 1));
  assign open_end   = tick && (us_cnt == open_us - 24'h1);
  assign period_end = tick && (us_cnt == period_us - 24'h1);
  assign last_dep   = (mode == VDS_TIMED) ? (remaining == 16'h1) : !init_s;

  assign start_ok = power_en && !purging && (state == VDS_IDLE) &&
                    (((mode == VDS_TIMED) && init_rise) || ((mode == VDS_CONT) && init_s));
  assign restart  = start_ok || (period_end && (state != VDS_IDLE) && !last_dep);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre    <= 4'h0;
      us_cnt <= 24'h0;
    end else if (restart) begin
      pre    <= 4'h0;
      us_cnt <= 24'h0;
    end else if (tick) begin
      pre    <= 4'h0;
      us_cnt <= us_cnt + 24'h1;
    end else begin
      pre <= pre + 4'h1;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      VDS_IDLE: begin
        if (start_ok) begin
          next_state = VDS_OPEN;
        end
      end
      VDS_OPEN: begin
        if (period_end) begin
          next_state = last_dep ? VDS_IDLE : VDS_OPEN;
        end else if (open_end) begin
          next_state = VDS_GAP;
        end
      end
      VDS_GAP: begin
        if (period_end) begin
          next_state = last_dep ? VDS_IDLE : VDS_OPEN;
        end
      end
      default: next_state = VDS_IDLE;
    endcase
    if (!power_en || mode == VDS_EXT) begin
      next_state = VDS_IDLE;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= VDS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // deposits left in the timed burst
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      remaining <= 16'h0;
    end else if (start_ok) begin
      remaining <= count_cfg;
    end else if (next_state == VDS_IDLE) begin
      remaining <= 16'h0;
    end else if (period_end && mode == VDS_TIMED) begin
      remaining <= remaining - 16'h1;
    end
  end

  // valve drive; external timing trusted to the far side
  assign valve_open = (state == VDS_OPEN) || purging ||
                      ((mode == VDS_EXT) && ext_s);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      valve_close <= 1'b0;
      dispensing  <= 1'b0;
    end else begin
      valve_close <= power_en && !valve_open;
      dispensing  <= (next_state != VDS_IDLE);
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_purge_start;
    !purging ##1 purging;
  endsequence

  sequence s_ext_level;
    (mode == VDS_EXT) && power_en && !purging && (state == VDS_IDLE);
  endsequence

  sequence s_rest_closed;
    power_en && (state == VDS_IDLE) && !purging && (mode != VDS_EXT);
  endsequence

  sequence s_period_wrap;
    power_en && (mode != VDS_EXT) && (state != VDS_IDLE) && period_end && !last_dep;
  endsequence

  a_purge_needs_power: assert property (s_purge_start |-> $past(power_en))
    else $error("purge started with power off");
  a_purge_idle_only: assert property (s_purge_start |-> $past(!dispensing))
    else $error("purge started while dispensing");
  a_purge_no_error: assert property (s_purge_start |-> $past(!err_s))
    else $error("purge started under error");
  a_purge_toggle_off: assert property (purging && purge_req |=> !purging)
    else $error("second purge request did not stop purge");
  a_ext_follow: assert property (s_ext_level ##1 s_ext_level |-> valve_close == !$past(ext_s))
    else $error("valve does not follow external drive");
  a_power_off_open: assert property (!power_en ##1 !power_en |-> !valve_close)
    else $error("valve driven closed with power off");
  a_count_valid: assert property (count_cfg != 16'h0)
    else $error("deposit count left its range");
  a_start_power: assert property ($rose(dispensing) |-> $past(power_en))
    else $error("sequence started with power off");
  a_timed_no_retrig: assert property (
    (mode == VDS_TIMED) && power_en && (state != VDS_IDLE) && !period_end |=> remaining == $past(remaining))
    else $error("initiate restarted a running sequence");
  a_cont_stop: assert property (
    (mode == VDS_CONT) && power_en && (state == VDS_GAP) && period_end && !init_s |=> state == VDS_IDLE)
    else $error("continuous mode ran past inactive initiate");
  a_open_gap: assert property (
    power_en && (mode != VDS_EXT) && state == VDS_OPEN && open_end && !period_end |=> state == VDS_GAP)
    else $error("open time not ended on time");
  a_burst_end: assert property (
    (mode == VDS_TIMED) && power_en && state != VDS_IDLE && period_end && remaining == 16'h1 |=> state == VDS_IDLE)
    else $error("timed burst did not end after its count");
  a_power_gate_idle: assert property (!power_en |=> state == VDS_IDLE)
    else $error("sequence kept running with power off");
  a_closed_at_rest: assert property (s_rest_closed |=> valve_close)
    else $error("valve not driven closed at rest");
  a_purge_open: assert property (purging |=> !valve_close)
    else $error("valve driven closed during purge");
  a_period_restart: assert property (s_period_wrap |=> (state == VDS_OPEN) && (us_cnt == 24'h0))
    else $error("next deposit did not start at period end");
  a_cont_repeat: assert property (
    (mode == VDS_CONT) && power_en && (state != VDS_IDLE) && period_end && init_s |=> state == VDS_OPEN)
    else $error("continuous mode stopped with initiate active");
  a_burst_load: assert property ((mode == VDS_TIMED) && start_ok |=> remaining == $past(count_cfg))
    else $error("timed burst not loaded with deposit count");
endmodule
`default_nettype wire

// ==== bench/vds_valve_model.sv ====
/* vds_valve_model: valve driver and initiate source facing the sequencer.
   Assumes the sequencer's ref_clk; measures every valve opening. */
`default_nettype none
module vds_valve_model #(
  parameter int EXT_MIN = 1500
) (
  // bench control
  input  wire logic   ref_clk,
  input  wire logic   clr,
  input  wire logic   init_req,
  input  wire logic   ext_req,
  // sequencer pins
  input  wire logic   valve_close,
  output logic        initiate_pin,
  output logic        ext_drive_pin,
  // measurements
  output logic [15:0] n_open,
  output logic [31:0] open_len,
  output logic [31:0] start_gap
);
  timeunit 1ns;
  timeprecision 1ns;
  int   hold;
  int   run;
  int   since;
  logic was_closed;
  // external pulses stretched past the opening ramp
  always @(posedge ref_clk) begin
    initiate_pin <= init_req;
    hold <= ext_req ? EXT_MIN : (hold > 0 ? hold - 1 : 0);
    ext_drive_pin <= ext_req || hold > 0;
  end
  // valve is open whenever close drive is absent
  always @(posedge ref_clk) begin
    was_closed <= valve_close;
    since <= since + 1;
    if (clr) begin
      n_open <= 16'h0;
    end else if (!valve_close && was_closed) begin
      n_open <= n_open + 16'h1;
      start_gap <= since;
      since <= 1;
      run <= 1;
    end else if (!valve_close) begin
      run <= run + 1;
    end else if (!was_closed) begin
      open_len <= run;
    end
  end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
/* tb: self-checking bench for vds_top over APB with the valve model.
   Assumes APB answers within 20 cycles of penable and microsecond time settings. */
`default_nettype none
module tb
  import vds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         ref_clk, rst, err, clr, ini_rq, ext_rq, ini, ext, vc, disp, e;
  logic [15:0]  n_open;
  logic [31:0]  open_len, gap, q;
  vds_apb_req_t req;
  vds_apb_rsp_t rsp;
  int           n_fail, compares;

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  vds_top vds_top_inst (.ref_clk(ref_clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .initiate_pin(ini), .ext_drive_pin(ext), .error_pin(err), .valve_close(vc), .dispensing(disp));
  vds_valve_model vds_valve_model_inst (.ref_clk(ref_clk), .clr(clr), .init_req(ini_rq),
    .ext_req(ext_rq), .valve_close(vc), .initiate_pin(ini), .ext_drive_pin(ext),
    .n_open(n_open), .open_len(open_len), .start_gap(gap));

  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    req <= {1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      n_fail++;
      give_verdict();
    end else begin
      q = rsp.prdata;
      e = rsp.pslverr;
      req <= '0;
    end
  endtask

  task automatic wt(input logic lvl, input int lim);
    int n;
    n = 0;
    while (disp !== lvl && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    if (disp !== lvl) begin
      n_fail++;
      give_verdict();
    end
  endtask

  task automatic rs();
    tk(4);
    xfer(1'b0, OFS_STATUS, 32'h0);
  endtask

  task automatic start();
    clr <= 1'b1;
    ini_rq <= 1'b1;
    tk(1);
    clr <= 1'b0;
  endtask

  task automatic t_reset();
    tk(2);
    chk(vc, 32'h1);
    xfer(1'b0, OFS_CTRL, 32'h0);
    chk(q, 32'h4);
    xfer(1'b0, OFS_COUNT, 32'h0);
    chk(q, 32'h1);
    xfer(1'b1, OFS_COUNT, 32'h0);
    xfer(1'b0, OFS_COUNT, 32'h0);
    chk(q, 32'h1);
    xfer(1'b1, OFS_COUNT, 32'hffff);
    xfer(1'b0, OFS_COUNT, 32'h0);
    chk(q, 32'hffff);
    xfer(1'b1, OFS_PERIOD, {8'h0, PERIOD_MIN_US - 24'h1});
    xfer(1'b0, OFS_PERIOD, 32'h0);
    chk(q, {8'h0, PERIOD_RST});
    xfer(1'b0, 8'h14, 32'h0);
    chk(e, 32'h1);
    rs();
    chk(q[15:0], 32'h4);
    $display("reset test done");
  endtask

  task automatic t_timed();
    xfer(1'b1, OFS_COUNT, 32'h2);
    xfer(1'b1, OFS_PERIOD, {8'h0, PERIOD_MIN_US});
    xfer(1'b1, OFS_OPEN, {8'h0, OPEN_MIN_US});
    start();
    tk(3);
    ini_rq <= 1'b0;
    wt(1'b1, 20);
    tk(50);
    ini_rq <= 1'b1;
    xfer(1'b1, OFS_CTRL, 32'hc);
    ini_rq <= 1'b0;
    rs();
    chk(q[1:0], 32'h1);
    wt(1'b0, 45000);
    chk(n_open, 32'h2);
    chk(open_len, {8'h0, OPEN_MIN_US} * 32'ha);
    chk(gap, {8'h0, PERIOD_MIN_US} * 32'ha);
    tk(20);
    chk(disp, 32'h0);
    $display("timed test done");
  endtask

  task automatic t_cont();
    xfer(1'b1, OFS_COUNT, 32'h1);
    xfer(1'b1, OFS_CTRL, 32'h5);
    start();
    wt(1'b1, 20);
    tk(30000);
    ini_rq <= 1'b0;
    wt(1'b0, 20000);
    chk(n_open, 32'h2);
    $display("continuous test done");
  endtask

  task automatic t_ext();
    xfer(1'b1, OFS_CTRL, 32'h6);
    ext_rq <= 1'b1;
    tk(10);
    chk(vc, 32'h0);
    ext_rq <= 1'b0;
    tk(1600);
    chk(vc, 32'h1);
    xfer(1'b1, OFS_CTRL, 32'h0);
    tk(5);
    chk(vc, 32'h0);
    start();
    tk(5);
    ini_rq <= 1'b0;
    tk(5);
    chk(disp, 32'h0);
    xfer(1'b1, OFS_CTRL, 32'h8);
    rs();
    chk(q[1], 32'h0);
    $display("external and power test done");
  endtask

  task automatic t_purge();
    xfer(1'b1, OFS_CTRL, 32'h4);
    err <= 1'b1;
    tk(4);
    xfer(1'b1, OFS_CTRL, 32'hc);
    rs();
    chk(q[3:1], 32'h6);
    err <= 1'b0;
    tk(4);
    xfer(1'b1, OFS_CTRL, 32'hc);
    rs();
    chk(q[2:1], 32'h1);
    xfer(1'b1, OFS_CTRL, 32'hc);
    rs();
    chk(q[2:1], 32'h2);
    $display("purge test done");
  endtask

  initial begin
    rst = 1'b1;
    err = 1'b0;
    clr = 1'b0;
    ini_rq = 1'b0;
    ext_rq = 1'b0;
    req = '0;
    n_fail = 0;
    compares = 0;
    tk(12);
    rst <= 1'b0;
    t_reset();
    t_timed();
    t_cont();
    t_ext();
    t_purge();
    give_verdict();
  end
endmodule
`default_nettype wire
